/* File: core/can_trx_ctrl_regs.vh */
// Register map and timing constants of the CAN FD transceiver control block
`ifndef CAN_TRX_CTRL_REGS_VH
`define CAN_TRX_CTRL_REGS_VH
// ----------------------------------------------------------------------------
// Register word addresses (Avalon word aligned)
// ----------------------------------------------------------------------------
`define CTL_ADDR        4'h0
`define STAT_ADDR       4'h1
`define IRQ_STAT_ADDR   4'h2
`define IRQ_MASK_ADDR   4'h3
`define FAULT_ADDR      4'h4
// ----------------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------------
`define CTL_ACT_BIT     0
`define CTL_LISTEN_BIT  1
`define CTL_LOOP_BIT    2
`define CTL_WUEN_BIT    3
`define CTL_ABIAS_BIT   4
`define CTL_STBY0_BIT   5
`define CTL_STBY1_BIT   6
`define CTL_TXTO_EN_BIT 7
`define CTL_RESET       8'h00
// ----------------------------------------------------------------------------
// Fault flag positions
// ----------------------------------------------------------------------------
`define FLT_TXDOM       0
`define FLT_BUSREC      1
`define FLT_BUSDOM      2
`define FLT_RXREC       3
`define FLT_TSD         4
// ----------------------------------------------------------------------------
// Interrupt status positions
// ----------------------------------------------------------------------------
`define IRQ_WAKE        0
`define IRQ_FAULT       1
// ----------------------------------------------------------------------------
// Timing, times in ns, clock period 5 ns
// ----------------------------------------------------------------------------
`define CLK_NS          5
`define TXDOM_NS        1000000
`define BUSDOM_NS       1000000
`define FILTER_NS       1000
`define WAKE_NS         1000000
`define FOLLOW_NS       2000
`define RSTPULSE_NS     2000000
`define BIASTO_NS       1000000
`define FAIL_COUNT      3'h4
`endif

/* File: core/can_trx_ctrl.v */
// CAN FD transceiver control: modes, fault detectors, wake-up and register slave
`timescale 1ns/1ps
`default_nettype none
`include "can_trx_ctrl_regs.vh"
module can_trx_ctrl (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire        transmitDataIn,
  output reg         receiveDataOut,
  input  wire        busRxLevel,
  output reg         busTxDominant,
  output reg         transmitterEnable,
  output reg         receiverEnable,
  output reg         biasEnable,
  input  wire        thermalShutdown,
  output wire        irq,
  output reg         resetOutputLow
);
  // ----------------------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------------------
  localparam integer TXDOM_N  = `TXDOM_NS / `CLK_NS;
  localparam integer BUSDOM_N = `BUSDOM_NS / `CLK_NS;
  localparam integer FILT_N   = (`FILTER_NS + `CLK_NS - 1) / `CLK_NS;
  localparam integer WAKE_N   = `WAKE_NS / `CLK_NS;
  localparam integer FOLLOW_N = `FOLLOW_NS / `CLK_NS;
  localparam integer RSTP_N   = (`RSTPULSE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam integer BIAS_N   = `BIASTO_NS / `CLK_NS;
  // Cut to the 24-bit counter width; every count fits well below that
  localparam [23:0] TXDOM_CYC  = TXDOM_N[23:0];
  localparam [23:0] BUSDOM_CYC = BUSDOM_N[23:0];
  localparam [23:0] FILT_CYC   = FILT_N[23:0];
  localparam [23:0] WAKE_CYC   = WAKE_N[23:0];
  localparam [23:0] FOLLOW_CYC = FOLLOW_N[23:0];
  localparam [23:0] RSTP_CYC   = RSTP_N[23:0];
  localparam [23:0] BIAS_CYC   = BIAS_N[23:0];
  localparam [1:0] M_OFF  = 2'h0;
  localparam [1:0] M_NORM = 2'h1;
  localparam [1:0] M_SB1  = 2'h2;
  localparam [1:0] M_SBB  = 2'h3;
  localparam [1:0] W_IDLE = 2'h0;
  localparam [1:0] W_DOM1 = 2'h1;
  localparam [1:0] W_GAP  = 2'h2;
  localparam [1:0] W_DOM2 = 2'h3;

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  reg [1:0] txdS_r;
  reg [1:0] busS_r;
  reg [1:0] tsdS_r;
  wire txd = txdS_r[1];
  wire bus = busS_r[1];
  wire tsd = tsdS_r[1];
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txdS_r <= 2'b11;
      busS_r <= 2'b11;
      tsdS_r <= 2'b00;
    end else begin
      txdS_r <= {txdS_r[0], transmitDataIn};
      busS_r <= {busS_r[0], busRxLevel};
      tsdS_r <= {tsdS_r[0], thermalShutdown};
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  reg [7:0]  ctl_r;
  reg [4:0]  fault_r;
  reg [1:0]  irqStat_r;
  reg [1:0]  irqMask_r;
  reg [1:0]  mode_r;
  reg [1:0]  wst_r;
  reg [23:0] txCnt_r;
  reg [23:0] domCnt_r;
  reg [23:0] wCnt_r;
  reg [23:0] winCnt_r;
  reg [23:0] folCnt_r;
  reg [23:0] rstCnt_r;
  reg [23:0] biasCnt_r;
  reg [2:0]  busMiss_r;
  reg [2:0]  rxMiss_r;
  reg        txdPrev_r;
  reg        checkPend_r;
  reg        busSeen_r;
  reg        rxSeen_r;
  reg        wakeEv;
  reg [4:0]  faultSet;
  reg        rdDone_r;

  wire wr = write;
  // Read taken on its first edge; the second edge hands the data over
  wire rdTake = read & ~rdDone_r;
  wire newFall = txdPrev_r & ~txd & transmitterEnable;
  wire folEnd = checkPend_r & ~newFall & (folCnt_r == FOLLOW_CYC);
  wire inStby = (mode_r == M_SB1) || (mode_r == M_SBB);
  wire txBlock = fault_r[`FLT_TXDOM] | fault_r[`FLT_BUSREC] | fault_r[`FLT_RXREC] | fault_r[`FLT_TSD];
  wire txAllowed = (mode_r == M_NORM) & ~ctl_r[`CTL_LISTEN_BIT] & ~txBlock;

  assign waitrequest = rdTake;
  assign irq = |(irqStat_r & irqMask_r);

  // ----------------------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_r <= M_OFF;
    end else begin
      case (mode_r)
        M_OFF, M_SB1, M_SBB: begin
          // Wake only flags (SB1) or pulses resetOutputLow (SBB); software must set activation again
          if (wr && address == `CTL_ADDR && writedata[`CTL_ACT_BIT])
            mode_r <= M_NORM;
        end
        M_NORM: begin
          if (ctl_r[`CTL_STBY1_BIT])
            mode_r <= M_SBB;
          else if (ctl_r[`CTL_STBY0_BIT])
            mode_r <= M_SB1;
          else if (!ctl_r[`CTL_ACT_BIT])
            mode_r <= M_OFF;
        end
        default: mode_r <= M_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Register slave: writes take no wait, reads one
  // ----------------------------------------------------------------------------
  // Wait state keeps readdata a flop and still standing at the answer edge
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdDone_r <= 1'b0;
    end else begin
      rdDone_r <= rdTake;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_r     <= `CTL_RESET;
      irqMask_r <= 2'b00;
      readdata  <= 32'h0000_0000;
    end else begin
      if (wr && address == `CTL_ADDR) begin
        ctl_r <= writedata[7:0];
      end else if (mode_r == M_NORM && (ctl_r[`CTL_STBY0_BIT] | ctl_r[`CTL_STBY1_BIT])) begin
        // Entering standby drops activation so wake never reactivates alone
        ctl_r[`CTL_ACT_BIT]   <= 1'b0;
        ctl_r[`CTL_STBY0_BIT] <= 1'b0;
        ctl_r[`CTL_STBY1_BIT] <= 1'b0;
      end
      if (wr && address == `IRQ_MASK_ADDR)
        irqMask_r <= writedata[1:0];
      if (rdTake) begin
        case (address)
          `CTL_ADDR:      readdata <= {24'h00_0000, ctl_r};
          `STAT_ADDR:     readdata <= {24'h00_0000, 1'b0, biasEnable, transmitterEnable, 3'b000, mode_r};
          `IRQ_STAT_ADDR: readdata <= {30'h0000_0000, irqStat_r};
          `IRQ_MASK_ADDR: readdata <= {30'h0000_0000, irqMask_r};
          `FAULT_ADDR:    readdata <= {27'h000_0000, fault_r};
          default:        readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Fault detectors
  // ----------------------------------------------------------------------------
  always @* begin
    faultSet = 5'b00000;
    faultSet[`FLT_TXDOM]  = ctl_r[`CTL_TXTO_EN_BIT] == 1'b0 && txCnt_r == TXDOM_CYC;
    faultSet[`FLT_BUSDOM] = domCnt_r == BUSDOM_CYC;
    // Fourth miss is the event; the saturated count alone would undo a clear
    faultSet[`FLT_BUSREC] = folEnd && !busSeen_r && (busMiss_r == (`FAIL_COUNT - 3'h1));
    faultSet[`FLT_RXREC]  = folEnd && !rxSeen_r && (rxMiss_r == (`FAIL_COUNT - 3'h1));
    faultSet[`FLT_TSD]    = tsd;
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fault_r     <= 5'b00000;
      txCnt_r     <= 24'h00_0000;
      domCnt_r    <= 24'h00_0000;
      folCnt_r    <= 24'h00_0000;
      busMiss_r   <= 3'b000;
      rxMiss_r    <= 3'b000;
      txdPrev_r   <= 1'b1;
      checkPend_r <= 1'b0;
      busSeen_r   <= 1'b0;
      rxSeen_r    <= 1'b0;
    end else begin
      txdPrev_r <= txd;
      // Write-one-to-clear; a new detection wins over the clear
      if (wr && address == `FAULT_ADDR)
        fault_r <= (fault_r & ~writedata[4:0]) | faultSet;
      else
        fault_r <= fault_r | faultSet;
      if (!txd && mode_r == M_NORM && txCnt_r != TXDOM_CYC)
        txCnt_r <= txCnt_r + 24'h00_0001;
      else if (txd)
        txCnt_r <= 24'h00_0000;
      if (!bus && domCnt_r != BUSDOM_CYC)
        domCnt_r <= domCnt_r + 24'h00_0001;
      else if (bus)
        domCnt_r <= 24'h00_0000;
      // Follow check only while transmitterEnable is set, loopback included where the bus is not driven
      if (newFall) begin
        checkPend_r <= 1'b1;
        folCnt_r    <= 24'h00_0000;
        busSeen_r   <= 1'b0;
        rxSeen_r    <= 1'b0;
      end else if (checkPend_r) begin
        folCnt_r <= folCnt_r + 24'h00_0001;
        if (!bus)
          busSeen_r <= 1'b1;
        if (!receiveDataOut)
          rxSeen_r <= 1'b1;
        if (folCnt_r == FOLLOW_CYC) begin
          checkPend_r <= 1'b0;
          if (!busSeen_r && busMiss_r != `FAIL_COUNT)
            busMiss_r <= busMiss_r + 3'b001;
          if (!rxSeen_r && rxMiss_r != `FAIL_COUNT)
            rxMiss_r <= rxMiss_r + 3'b001;
        end
      end
      if (wr && address == `FAULT_ADDR && writedata[`FLT_BUSREC])
        busMiss_r <= 3'b000;
      if (wr && address == `FAULT_ADDR && writedata[`FLT_RXREC])
        rxMiss_r <= 3'b000;
    end
  end

  // ----------------------------------------------------------------------------
  // Wake pattern detector
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wst_r    <= W_IDLE;
      wCnt_r   <= 24'h00_0000;
      winCnt_r <= 24'h00_0000;
      wakeEv   <= 1'b0;
    end else begin
      wakeEv <= 1'b0;
      if (!inStby || !ctl_r[`CTL_WUEN_BIT]) begin
        wst_r <= W_IDLE;
      end else begin
        winCnt_r <= winCnt_r + 24'h00_0001;
        wCnt_r   <= wCnt_r + 24'h00_0001;
        case (wst_r)
          W_IDLE: begin
            // A bus already dominant at entry counts as first pulse start
            if (!bus) begin
              wst_r    <= W_DOM1;
              wCnt_r   <= 24'h00_0000;
              winCnt_r <= 24'h00_0000;
            end
          end
          W_DOM1: begin
            if (bus) begin
              wst_r  <= (wCnt_r >= FILT_CYC) ? W_GAP : W_IDLE;
              wCnt_r <= 24'h00_0000;
            end
          end
          W_GAP: begin
            if (!bus) begin
              wst_r  <= (wCnt_r >= FILT_CYC) ? W_DOM2 : W_IDLE;
              wCnt_r <= 24'h00_0000;
            end
          end
          W_DOM2: begin
            if (bus) begin
              wst_r <= W_IDLE;
            end else if (wCnt_r == FILT_CYC) begin
              wakeEv <= 1'b1;
              wst_r  <= W_IDLE;
            end
          end
          default: wst_r <= W_IDLE;
        endcase
        if (wst_r != W_IDLE && winCnt_r == WAKE_CYC)
          wst_r <= W_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt status and reset pulse
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStat_r      <= 2'b00;
      rstCnt_r       <= 24'h00_0000;
      resetOutputLow <= 1'b1;
    end else begin
      // Read clears; set wins over the clear
      irqStat_r <= ((rdTake && address == `IRQ_STAT_ADDR) ? 2'b00 : irqStat_r)
                 | {(|faultSet), wakeEv && mode_r == M_SB1};
      if (wakeEv && mode_r == M_SBB) begin
        rstCnt_r       <= RSTP_CYC;
        resetOutputLow <= 1'b0;
      end else if (rstCnt_r != 24'h00_0000) begin
        rstCnt_r <= rstCnt_r - 24'h00_0001;
        if (rstCnt_r == 24'h00_0001)
          resetOutputLow <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs to bus and controller
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transmitterEnable <= 1'b0;
      receiverEnable    <= 1'b0;
      biasEnable        <= 1'b0;
      busTxDominant     <= 1'b0;
      receiveDataOut    <= 1'b1;
      biasCnt_r         <= 24'h00_0000;
    end else begin
      transmitterEnable <= txAllowed;
      receiverEnable    <= mode_r == M_NORM;
      busTxDominant     <= txAllowed & ~txd & ~ctl_r[`CTL_LOOP_BIT];
      if (!bus)
        biasCnt_r <= 24'h00_0000;
      else if (biasCnt_r != BIAS_CYC)
        biasCnt_r <= biasCnt_r + 24'h00_0001;
      if (mode_r == M_NORM)
        biasEnable <= 1'b1;
      else if (inStby)
        biasEnable <= ctl_r[`CTL_ABIAS_BIT] ? (biasCnt_r != BIAS_CYC) : 1'b1;
      else
        biasEnable <= 1'b0;
      if (mode_r != M_NORM)
        receiveDataOut <= 1'b1;
      else if (ctl_r[`CTL_LOOP_BIT])
        receiveDataOut <= txd;
      else
        receiveDataOut <= bus;
    end
  end
endmodule // can_trx_ctrl
`default_nettype wire

/* File: sim/can_bus_model.sv */
// Behavioural CAN bus seen from the transceiver pins
`timescale 1ns/1ps
`default_nettype none
module can_bus_model (
  input  wire logic busTxDominant,
  input  wire logic stuckRec,
  input  wire logic forceDom,
  output wire logic busRxLevel
);
  // Wired bus: recessive by pull, dominant if any node drives; a stuck bus ignores every driver
  assign busRxLevel = stuckRec ? 1'b1 : ~(busTxDominant | forceDom);
endmodule // can_bus_model
`default_nettype wire

/* File: sim/can_trx_ctrl_chk.sv */
// Port-level assertions for the transceiver control block
`timescale 1ns/1ps
`default_nettype none
module can_trx_ctrl_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        transmitDataIn,
  input wire logic        busTxDominant,
  input wire logic        transmitterEnable,
  input wire logic        receiverEnable,
  input wire logic        biasEnable,
  input wire logic        thermalShutdown,
  input wire logic        resetOutputLow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence txdHeldLow;
    (transmitterEnable && !transmitDataIn) [*4];
  endsequence
  sequence hotHeld;
    thermalShutdown [*6];
  endsequence
  AST_TSD_TX_OFF: assert property (hotHeld |-> !transmitterEnable) else $error("tx on while hot");
  AST_TSD_RX_ON: assert property ($rose(thermalShutdown) && receiverEnable |-> receiverEnable [*8])
    else $error("receiver dropped on fault");
  AST_TX_FOLLOW: assert property (txdHeldLow |-> busTxDominant) else $error("bus not driven");
  AST_TX_GATED: assert property (!transmitterEnable [*2] |-> !busTxDominant)
    else $error("bus driven while tx off");
  AST_BIAS_NORMAL: assert property (transmitterEnable [*2] |-> biasEnable) else $error("bias off");
  AST_RSTOUT_HOLD: assert property ($fell(resetOutputLow) |-> !resetOutputLow [*8])
    else $error("reset pulse too short");
  AST_UNMAPPED_RD: assert property (read && address > 4'h4 |=> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_TX_RISE_WRITE: assert property ($rose(transmitterEnable) |-> $past(write, 1) || $past(write, 2)
    || $past(write, 3)) else $error("tx enabled without software");
endmodule // can_trx_ctrl_chk
bind can_trx_ctrl can_trx_ctrl_chk u_chk (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
  .write(write), .readdata(readdata), .transmitDataIn(transmitDataIn), .busTxDominant(busTxDominant),
  .transmitterEnable(transmitterEnable), .receiverEnable(receiverEnable), .biasEnable(biasEnable),
  .thermalShutdown(thermalShutdown), .resetOutputLow(resetOutputLow));
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the CAN transceiver control block
`timescale 1ns/1ps
`default_nettype none
`include "can_trx_ctrl_regs.vh"
module tb;
  logic        sys_clk, rst, read, write, transmitDataIn, thermalShutdown, stuckRec, forceDom, b;
  logic [3:0]  address;
  logic [31:0] writedata, d;
  wire  [31:0] readdata;
  wire         waitrequest, receiveDataOut, busRxLevel, busTxDominant, irq, resetOutputLow;
  wire         transmitterEnable, receiverEnable, biasEnable;
  integer      seed, badCount, cmpCount, i;
  always #2.5 sys_clk = ~sys_clk;
  can_trx_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .transmitDataIn(transmitDataIn), .receiveDataOut(receiveDataOut), .busRxLevel(busRxLevel),
    .busTxDominant(busTxDominant), .transmitterEnable(transmitterEnable), .receiverEnable(receiverEnable),
    .biasEnable(biasEnable), .thermalShutdown(thermalShutdown), .irq(irq), .resetOutputLow(resetOutputLow));
  can_bus_model u_bus (.busTxDominant(busTxDominant), .stuckRec(stuckRec), .forceDom(forceDom),
    .busRxLevel(busRxLevel));
  // ----------------------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    write <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Read data taken at the edge where waitrequest is seen low
  task rd(input logic [3:0] a, output logic [31:0] v);
    address <= a;
    read <= 1'b1;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    v = readdata;
    read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task pulses(input int w);
    forceDom <= 1'b1;
    cyc(w);
    forceDom <= 1'b0;
    cyc(300);
    forceDom <= 1'b1;
    cyc(w);
    forceDom <= 1'b0;
    cyc(20);
  endtask
  function automatic logic [31:0] statusExp(input logic [1:0] mode, input logic txOn, input logic bias);
    statusExp = {25'h0, bias, txOn, 3'h0, mode};
  endfunction
  task testDone;
    if (badCount == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  initial begin
    sys_clk = 0; rst = 1; address = 0; read = 0; write = 0; writedata = 0; transmitDataIn = 1;
    thermalShutdown = 0; stuckRec = 0; forceDom = 0; seed = 32'h24cc; badCount = 0; cmpCount = 0;
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    rd(`CTL_ADDR, d);
    chk(d, `CTL_RESET);
    rd(`STAT_ADDR, d);
    chk(d, statusExp(2'h0, 1'b0, 1'b0));
    for (i = 5; i < 16; i++) begin
      wr(i[3:0], $random(seed));
      rd(i[3:0], d);
      chk(d, 32'h0000_0000);
    end
    wr(`CTL_ADDR, 32'h0000_0001);
    cyc(4);
    chk({transmitterEnable, receiverEnable, biasEnable, irq}, 4'hE);
    rd(`STAT_ADDR, d);
    chk(d, statusExp(2'h1, 1'b1, 1'b1));
    repeat (20) begin
      b = $random(seed);
      transmitDataIn <= b;
      cyc(20);
      chk({busTxDominant, receiveDataOut}, {~b, b});
    end
    transmitDataIn <= 1'b1;
    wr(`CTL_ADDR, 32'h0000_0007);
    cyc(4);
    chk({transmitterEnable, receiverEnable}, 2'h1);
    for (i = 0; i < 2; i++) begin
      transmitDataIn <= i[0];
      cyc(8);
      chk({busTxDominant, receiveDataOut}, {1'b0, i[0]});
    end
    wr(`CTL_ADDR, 32'h0000_0001);
    wr(`IRQ_MASK_ADDR, 32'h0000_0002);
    stuckRec <= 1'b1;
    repeat (4) begin
      transmitDataIn <= 1'b0;
      cyc(450);
      transmitDataIn <= 1'b1;
      cyc(50);
    end
    chk({transmitterEnable, receiverEnable, irq}, 3'h3);
    rd(`FAULT_ADDR, d);
    chk(d[`FLT_BUSREC], 1'b1);
    rd(`IRQ_STAT_ADDR, d);
    chk({d[`IRQ_FAULT], irq}, 2'h2);
    stuckRec <= 1'b0;
    wr(`FAULT_ADDR, 32'h0000_001F);
    cyc(4);
    chk(transmitterEnable, 1'b1);
    thermalShutdown <= 1'b1;
    cyc(10);
    chk({transmitterEnable, receiverEnable}, 2'h1);
    thermalShutdown <= 1'b0;
    cyc(10);
    chk(transmitterEnable, 1'b0);
    rd(`FAULT_ADDR, d);
    chk(d[`FLT_TSD], 1'b1);
    wr(`FAULT_ADDR, 32'h0000_0001 << `FLT_TSD);
    cyc(4);
    chk(transmitterEnable, 1'b1);
    rd(`IRQ_STAT_ADDR, d);
    wr(`IRQ_MASK_ADDR, 32'h0000_0001);
    wr(`CTL_ADDR, 32'h0000_0028);
    cyc(4);
    chk({transmitterEnable, receiveDataOut}, 2'h1);
    rd(`STAT_ADDR, d);
    chk(d[1:0], 2'h2);
    pulses(100);
    chk(irq, 1'b0);
    pulses(300);
    chk(irq, 1'b1);
    rd(`IRQ_STAT_ADDR, d);
    chk(d[`IRQ_WAKE], 1'b1);
    rd(`STAT_ADDR, d);
    chk(d[1:0], 2'h2);
    cyc(32000);
    wr(`CTL_ADDR, 32'h0000_0001);
    cyc(4);
    chk(transmitterEnable, 1'b1);
    forceDom <= 1'b1;
    wr(`CTL_ADDR, 32'h0000_0048);
    cyc(50);
    forceDom <= 1'b0;
    cyc(300);
    pulses(300);
    chk(resetOutputLow, 1'b0);
    rd(`IRQ_STAT_ADDR, d);
    chk(d[`IRQ_WAKE], 1'b0);
    testDone;
  end
  initial begin
    #400000;
    badCount++;
    testDone;
  end
endmodule // tb
`default_nettype wire
